/* File: csf_pkg.sv */
// csf_pkg: constants and types of the cpu status flag unit.
// assumes one core clock; the execution unit issues at most one op per cycle.
// ****************************************************************
// Notes on behaviour
// ****************************************************************
package csf_pkg;
    // ****************************************************************
    // register map and reset values
    // ****************************************************************
    localparam logic [7:0] FLAGS_ADDR = 8'hD5;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [7:0] RDATA_IDLE = 8'h00;
    // ****************************************************************
    // bcd correction constants
    // ****************************************************************
    localparam logic [7:0] BCD_HI_ADJ = 8'h60;
    localparam logic [7:0] BCD_LO_ADJ = 8'h06;
    localparam logic [7:0] BCD_HI_LIMIT = 8'h99;
    localparam logic [3:0] BCD_LO_LIMIT = 4'h9;

    // ops issued by the execution unit, one per cycle
    typedef enum logic [4:0] {
        CSF_NOP = 5'b00000, CSF_ADD = 5'b00001, CSF_ADC = 5'b00010,
        CSF_SUB = 5'b00011, CSF_SBC = 5'b00100, CSF_CP = 5'b00101,
        CSF_AND = 5'b00110, CSF_OR = 5'b00111, CSF_XOR = 5'b01000,
        CSF_COM = 5'b01001, CSF_TEST = 5'b01010, CSF_ROT = 5'b01011,
        CSF_SCF = 5'b01100, CSF_RCF = 5'b01101, CSF_CCF = 5'b01110,
        CSF_DEC_ADJ = 5'b01111, CSF_BANK0 = 5'b10000, CSF_BANK1 = 5'b10001,
        CSF_FIRQ = 5'b10010, CSF_IRQ_RET = 5'b10011
    } csf_kind_t;

    // one op: operands and, for shifts, the bit pushed out
    typedef struct packed {
        csf_kind_t kind;
        logic [7:0] a;
        logic [7:0] b;
        logic shift_bit;
    } csf_op_t;

    // flag layout, bit 7 down to bit 0
    typedef struct packed {
        logic c;
        logic z;
        logic s;
        logic v;
        logic d;
        logic h;
        logic fast_irq;
        logic ba;
    } csf_flags_t;

    // adder outcome
    typedef struct packed {
        logic c;
        logic h;
        logic v;
        logic [7:0] res;
    } csf_arith_t;
endpackage

/* File: csf_flag_unit.sv */
// csf_flag_unit: status flag register of the core with its update logic.
// assumes op_in and the register port come from logic on clk_sys_in.
`timescale 1ns/1ps
module csf_flag_unit #(
    parameter int unsigned ADDR_W = 8
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire csf_pkg::csf_op_t op_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    output csf_pkg::csf_flags_t flags_out,
    output logic [3:0] cond_out,
    output logic [7:0] result_out,
    output logic bank_sel_out,
    output logic irq_inhibit_out,
    output logic fast_return_out
);
    import csf_pkg::*;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // one adder serves add, subtract and compare; sub adds the inverse
    function automatic csf_arith_t csf_arith(
        input logic [7:0] a,
        input logic [7:0] b,
        input logic cin,
        input logic sub
    );
        logic [7:0] bb;
        logic cx;
        logic [4:0] lo;
        logic [8:0] full;
        csf_arith_t r;
        bb = sub ? ~b : b;
        cx = sub ? ~cin : cin;
        lo = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cx};
        full = {1'b0, a} + {1'b0, bb} + {8'h00, cx};
        r.res = full[7:0];
        r.c = sub ? ~full[8] : full[8];
        r.h = sub ? ~lo[4] : lo[4];
        r.v = (a[7] == bb[7]) && (full[7] != a[7]);
        return r;
    endfunction

    // decimal correction after a binary add (d=0) or subtract (d=1)
    function automatic csf_arith_t csf_bcd(
        input logic [7:0] a,
        input logic c,
        input logic h,
        input logic d
    );
        logic hi;
        logic lo;
        logic [7:0] adj;
        csf_arith_t r;
        hi = c || (!d && (a > BCD_HI_LIMIT));
        lo = h || (!d && (a[3:0] > BCD_LO_LIMIT));
        adj = (hi ? BCD_HI_ADJ : 8'h00) | (lo ? BCD_LO_ADJ : 8'h00);
        r.res = d ? a - adj : a + adj;
        r.c = hi;
        r.h = h;
        r.v = 1'b0;
        return r;
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    csf_flags_t flags_ff;
    csf_flags_t nxt_flags;
    logic [7:0] result_ff;
    logic [7:0] nxt_result;
    logic [7:0] rdata_ff;
    logic fast_ret_ff;

    // ****************************************************************
    // decode
    // ****************************************************************
    // register port hits; other addresses read zero and drop writes
    wire logic hit_w = (reg_addr_in == ADDR_W'(FLAGS_ADDR));
    wire logic wr_hit_w = reg_wr_in && hit_w;
    wire logic rd_hit_w = reg_rd_in && hit_w;

    // operand routing for the shared adder
    wire logic is_sub_w = (op_in.kind == CSF_SUB) || (op_in.kind == CSF_SBC)
        || (op_in.kind == CSF_CP);
    wire logic use_cin_w = (op_in.kind == CSF_ADC) || (op_in.kind == CSF_SBC);
    wire logic cin_w = use_cin_w ? flags_ff.c : 1'b0;
    wire csf_arith_t sum_w = csf_arith(op_in.a, op_in.b, cin_w, is_sub_w);
    wire csf_arith_t bcd_w = csf_bcd(op_in.a, flags_ff.c, flags_ff.h, flags_ff.d);

    // logic results
    wire logic [7:0] and_w = op_in.a & op_in.b;
    wire logic [7:0] or_w = op_in.a | op_in.b;
    wire logic [7:0] xor_w = op_in.a ^ op_in.b;
    wire logic [7:0] com_w = ~op_in.a;

    // a direct write lands first, an op then overrides what it defines
    wire csf_flags_t base_w = wr_hit_w ? csf_flags_t'(reg_wdata_in) : flags_ff;

    // ****************************************************************
    // next flags and result
    // ****************************************************************
    // bits an op leaves alone pass on from base_w
    always_comb begin
        nxt_flags = base_w;
        nxt_result = result_ff;
        case (op_in.kind)
            CSF_ADD, CSF_ADC, CSF_SUB, CSF_SBC: begin
                nxt_flags.c = sum_w.c;
                nxt_flags.z = (sum_w.res == 8'h00);
                nxt_flags.s = sum_w.res[7];
                nxt_flags.v = sum_w.v;
                nxt_flags.d = is_sub_w;
                nxt_flags.h = sum_w.h;
                nxt_result = sum_w.res;
            end
            CSF_CP: begin
                // compare keeps the result, flags only
                nxt_flags.c = sum_w.c;
                nxt_flags.z = (sum_w.res == 8'h00);
                nxt_flags.s = sum_w.res[7];
                nxt_flags.v = sum_w.v;
            end
            CSF_AND: begin
                nxt_flags.z = (and_w == 8'h00);
                nxt_flags.s = and_w[7];
                nxt_flags.v = 1'b0;
                nxt_result = and_w;
            end
            CSF_OR: begin
                nxt_flags.z = (or_w == 8'h00);
                nxt_flags.s = or_w[7];
                nxt_flags.v = 1'b0;
                nxt_result = or_w;
            end
            CSF_XOR: begin
                nxt_flags.z = (xor_w == 8'h00);
                nxt_flags.s = xor_w[7];
                nxt_flags.v = 1'b0;
                nxt_result = xor_w;
            end
            CSF_COM: begin
                nxt_flags.z = (com_w == 8'h00);
                nxt_flags.s = com_w[7];
                nxt_flags.v = 1'b0;
                nxt_result = com_w;
            end
            CSF_TEST: begin
                // masked test: the tested bits set the flags only, the result keeps its value
                nxt_flags.z = (and_w == 8'h00);
                nxt_flags.s = and_w[7];
                nxt_flags.v = 1'b0;
            end
            CSF_ROT: begin
                // shifter output arrives in b, the bit pushed out beside it
                nxt_flags.c = op_in.shift_bit;
                nxt_flags.z = (op_in.b == 8'h00);
                nxt_flags.s = op_in.b[7];
                nxt_result = op_in.b;
            end
            CSF_SCF: begin
                nxt_flags.c = 1'b1;
            end
            CSF_RCF: begin
                nxt_flags.c = 1'b0;
            end
            CSF_CCF: begin
                nxt_flags.c = ~flags_ff.c;
            end
            CSF_DEC_ADJ: begin
                nxt_flags.c = bcd_w.c;
                nxt_flags.z = (bcd_w.res == 8'h00);
                nxt_flags.s = bcd_w.res[7];
                nxt_result = bcd_w.res;
            end
            CSF_BANK0: begin
                nxt_flags.ba = 1'b0;
            end
            CSF_BANK1: begin
                nxt_flags.ba = 1'b1;
            end
            CSF_FIRQ: begin
                nxt_flags.fast_irq = 1'b1;
            end
            CSF_IRQ_RET: begin
                nxt_flags.fast_irq = 1'b0;
            end
            default: begin
                nxt_flags = base_w;
            end
        endcase
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    // flags and datapath result
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            flags_ff <= csf_flags_t'(FLAGS_RESET);
            result_ff <= RESULT_RESET;
        end else begin
            flags_ff <= nxt_flags;
            result_ff <= nxt_result;
        end
    end

    // read data stands one cycle only, so a stale value never lingers
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_ff <= RDATA_IDLE;
        end else begin
            rdata_ff <= rd_hit_w ? flags_ff : RDATA_IDLE;
        end
    end

    // return while fast irq is active takes the fast path
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            fast_ret_ff <= 1'b0;
        end else begin
            fast_ret_ff <= (op_in.kind == CSF_IRQ_RET) && flags_ff.fast_irq;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign reg_rdata_out = rdata_ff;
    assign flags_out = flags_ff;
    assign cond_out = flags_ff[7:4];
    assign result_out = result_ff;
    assign bank_sel_out = flags_ff.ba;
    assign irq_inhibit_out = flags_ff.fast_irq;
    assign fast_return_out = fast_ret_ff;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    sequence fast_taken_s;
        op_in.kind == CSF_FIRQ;
    endsequence

    sequence fast_held_s;
        flags_ff.fast_irq && irq_inhibit_out;
    endsequence

    sequence fast_ret_s;
        (op_in.kind == CSF_IRQ_RET) && flags_ff.fast_irq;
    endsequence

    fast_entry_a: assert property (fast_taken_s |=> fast_held_s)
        else $error("fast irq bit not set after entry");
    fast_return_a: assert property (fast_ret_s |=> fast_return_out && !flags_ff.fast_irq)
        else $error("fast return missing after return op");
    and_flags_a: assert property (
        op_in.kind == CSF_AND |=> (flags_ff.z == ($past(and_w) == 8'h00))
        && (flags_ff.s == $past(and_w[7])) && !flags_ff.v)
        else $error("and did not update zero sign overflow");
    add_carry_a: assert property (
        op_in.kind == CSF_ADD |=> flags_ff.c
        == (({1'b0, $past(op_in.a)} + {1'b0, $past(op_in.b)}) > 9'h0FF))
        else $error("add carry wrong");
    sub_borrow_a: assert property (
        op_in.kind == CSF_SUB |=> flags_ff.c == ($past(op_in.a) < $past(op_in.b))
        && flags_ff.d)
        else $error("sub borrow or decimal flag wrong");
    rot_carry_a: assert property (
        op_in.kind == CSF_ROT |=> flags_ff.c == $past(op_in.shift_bit)
        && flags_ff.z == ($past(op_in.b) == 8'h00) && flags_ff.s == $past(op_in.b[7]))
        else $error("shift flags wrong");
    carry_cpl_a: assert property (
        op_in.kind == CSF_CCF && !wr_hit_w |=> flags_ff.c != $past(flags_ff.c)
        && flags_ff[6:0] == $past(flags_ff[6:0]))
        else $error("carry complement wrong");
    half_carry_a: assert property (
        op_in.kind == CSF_ADD |=> flags_ff.h
        == (({1'b0, $past(op_in.a[3:0])} + {1'b0, $past(op_in.b[3:0])}) > 5'h0F)
        && !flags_ff.d)
        else $error("add half carry wrong");
    bank_one_a: assert property (op_in.kind == CSF_BANK1 |=> bank_sel_out)
        else $error("bank select not set");
    bank_zero_a: assert property (op_in.kind == CSF_BANK0 |=> !bank_sel_out)
        else $error("bank select not cleared");
    hold_flags_a: assert property (
        op_in.kind == CSF_NOP && !wr_hit_w |=> flags_ff == $past(flags_ff))
        else $error("flags changed without cause");
    direct_write_a: assert property (
        op_in.kind == CSF_NOP && wr_hit_w |=> flags_ff == $past(reg_wdata_in))
        else $error("direct write lost");
    read_back_a: assert property (
        rd_hit_w |=> reg_rdata_out == $past(flags_ff))
        else $error("read data wrong");
endmodule

/* File: csf_exec_model.sv */
// csf_exec_model: behavioural execution unit that issues ops to the flag unit.
// assumes the bench calls issue() one op at a time, never beside a flags write.
`timescale 1ns/1ps
module csf_exec_model (
    input wire logic clk_sys_in,
    output csf_pkg::csf_op_t op_out
);
    import csf_pkg::*;

    // idle op is nop with zero operands
    initial begin
        op_out = '0;
    end

    // ****************************************************************
    // issue one op for exactly one cycle
    // ****************************************************************
    // never overlapped with a flags write, so the two updates cannot collide
    task automatic issue(input csf_kind_t kind, input logic [7:0] a, input logic [7:0] b,
        input logic sb);
        @(posedge clk_sys_in);
        op_out <= '{kind: kind, a: a, b: b, shift_bit: sb};
        @(posedge clk_sys_in);
        op_out <= '0;
    endtask
endmodule

/* File: testbench.sv */
// testbench: self-checking bench for the cpu status flag unit.
// assumes csf_pkg is compiled first and the exec model drives op_in.
`timescale 1ns/1ps
module testbench;
    import csf_pkg::*;

    typedef struct {
        csf_kind_t kind;
        logic [7:0] a;
        logic [7:0] b;
        logic sb;
        logic [7:0] pre;
        logic [7:0] exp;
        logic [7:0] res;
        logic chk;
    } csf_tb_row_t;

    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    csf_op_t op_in;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_rdata_out;
    csf_flags_t flags_out;
    logic [3:0] cond_out;
    logic [7:0] result_out;
    logic bank_sel_out;
    logic irq_inhibit_out;
    logic fast_return_out;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    // flags order c z s v d h fis ba; pre is written before the op
    csf_tb_row_t rows[22] = '{
        '{CSF_ADD, 8'h7F, 8'h01, 1'b0, 8'h00, 8'h34, 8'h80, 1'b1},
        '{CSF_ADD, 8'hFF, 8'h01, 1'b0, 8'h00, 8'hC4, 8'h00, 1'b1},
        '{CSF_ADD, 8'h80, 8'h80, 1'b0, 8'h00, 8'hD0, 8'h00, 1'b1},
        '{CSF_ADC, 8'h10, 8'h0F, 1'b0, 8'h80, 8'h04, 8'h20, 1'b1},
        '{CSF_SUB, 8'h00, 8'h01, 1'b0, 8'h00, 8'hAC, 8'hFF, 1'b1},
        '{CSF_SUB, 8'h80, 8'h01, 1'b0, 8'h00, 8'h1C, 8'h7F, 1'b1},
        '{CSF_SBC, 8'h05, 8'h05, 1'b0, 8'h80, 8'hAC, 8'hFF, 1'b1},
        '{CSF_CP, 8'h05, 8'h05, 1'b0, 8'h0F, 8'h4F, 8'hFF, 1'b1},
        '{CSF_AND, 8'hF0, 8'h80, 1'b0, 8'hF0, 8'hA0, 8'h80, 1'b1},
        '{CSF_OR, 8'h00, 8'h00, 1'b0, 8'h10, 8'h40, 8'h00, 1'b1},
        '{CSF_XOR, 8'hFF, 8'h0F, 1'b0, 8'h00, 8'h20, 8'hF0, 1'b1},
        '{CSF_COM, 8'hFF, 8'h00, 1'b0, 8'h00, 8'h40, 8'h00, 1'b1},
        '{CSF_TEST, 8'hF0, 8'h0F, 1'b0, 8'h0C, 8'h4C, 8'h00, 1'b1},
        '{CSF_ROT, 8'h00, 8'h81, 1'b1, 8'h10, 8'hB0, 8'h81, 1'b1},
        '{CSF_ROT, 8'h00, 8'h00, 1'b0, 8'h80, 8'h40, 8'h00, 1'b1},
        '{CSF_SCF, 8'h00, 8'h00, 1'b0, 8'h00, 8'h80, 8'h00, 1'b1},
        '{CSF_RCF, 8'h00, 8'h00, 1'b0, 8'hFF, 8'h7F, 8'h00, 1'b0},
        '{CSF_CCF, 8'h00, 8'h00, 1'b0, 8'h7F, 8'hFF, 8'h00, 1'b0},
        '{CSF_DEC_ADJ, 8'h1A, 8'h00, 1'b0, 8'h00, 8'h00, 8'h20, 1'b1},
        '{CSF_DEC_ADJ, 8'h20, 8'h00, 1'b0, 8'h80, 8'hA0, 8'h80, 1'b1},
        '{CSF_DEC_ADJ, 8'h66, 8'h00, 1'b0, 8'h8C, 8'hCC, 8'h00, 1'b1},
        '{CSF_BANK0, 8'h00, 8'h00, 1'b0, 8'hFF, 8'hFE, 8'h00, 1'b0}
    };

    always #5 clk_sys_in = ~clk_sys_in;

    csf_exec_model csf_exec_model_inst (.clk_sys_in(clk_sys_in), .op_out(op_in));

    csf_flag_unit csf_flag_unit_inst (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .op_in(op_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .flags_out(flags_out),
        .cond_out(cond_out), .result_out(result_out), .bank_sel_out(bank_sel_out),
        .irq_inhibit_out(irq_inhibit_out), .fast_return_out(fast_return_out)
    );

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one-cycle write strobe, flags follow one cycle later
    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= addr;
        reg_wdata_in <= data;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= addr;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1;
        data = reg_rdata_out;
    endtask

    task automatic end_sim();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // hang guard: the whole run needs well under 1000 cycles
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            end_sim();
        end
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        logic [7:0] rd;
        repeat (8) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        #1;
        check("reset flags", FLAGS_RESET, flags_out);
        check("reset result", RESULT_RESET, result_out);
        // table rows: preset by direct write, then one op
        foreach (rows[i]) begin
            reg_write(FLAGS_ADDR, rows[i].pre);
            csf_exec_model_inst.issue(rows[i].kind, rows[i].a, rows[i].b, rows[i].sb);
            #1;
            check("flags", rows[i].exp, flags_out);
            check("cond", {4'h0, rows[i].exp[7:4]}, {4'h0, cond_out});
            check("bank", {7'h0, rows[i].exp[0]}, {7'h0, bank_sel_out});
            if (rows[i].chk) begin
                check("result", rows[i].res, result_out);
            end
        end
        // read back, stands one cycle, unmapped read and write refused
        reg_write(FLAGS_ADDR, 8'h5A);
        reg_read(FLAGS_ADDR, rd);
        check("rdata", 8'h5A, rd);
        @(posedge clk_sys_in);
        #1;
        check("rdata idle", RDATA_IDLE, reg_rdata_out);
        reg_write(8'hD4, 8'hFF);
        reg_read(8'hD4, rd);
        check("unmapped rdata", RDATA_IDLE, rd);
        check("unmapped write", 8'h5A, flags_out);
        // two ops issued with a nop cycle between them keep undefined flags
        csf_exec_model_inst.issue(CSF_BANK1, 8'h00, 8'h00, 1'b0);
        csf_exec_model_inst.issue(CSF_CCF, 8'h00, 8'h00, 1'b0);
        #1;
        check("b2b flags", 8'hDB, flags_out);
        // fast irq entry and return
        reg_write(FLAGS_ADDR, 8'h00);
        csf_exec_model_inst.issue(CSF_FIRQ, 8'h00, 8'h00, 1'b0);
        #1;
        check("fis set", 8'h02, flags_out);
        check("inhibit", 8'h01, {7'h0, irq_inhibit_out});
        csf_exec_model_inst.issue(CSF_IRQ_RET, 8'h00, 8'h00, 1'b0);
        #1;
        check("fast ret", 8'h01, {7'h0, fast_return_out});
        check("fis clear", 8'h00, flags_out);
        @(posedge clk_sys_in);
        #1;
        check("fast ret end", 8'h00, {7'h0, fast_return_out});
        // plain return without fast irq gives no pulse
        csf_exec_model_inst.issue(CSF_IRQ_RET, 8'h00, 8'h00, 1'b0);
        #1;
        check("plain ret", 8'h00, {7'h0, fast_return_out});
        // second reset in mid-run
        reg_write(FLAGS_ADDR, 8'hFF);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        #1;
        check("reset again", FLAGS_RESET, flags_out);
        check("reset result again", RESULT_RESET, result_out);
        rst_in <= 1'b0;
        // idle inputs after release must leave the reset state alone
        repeat (2) @(posedge clk_sys_in);
        #1;
        check("after release", FLAGS_RESET, flags_out);
        check("rdata after release", RDATA_IDLE, reg_rdata_out);
        end_sim();
    end
endmodule
